// File: logic/vdl_pkg.sv
package vdl_pkg;

    localparam int CLK_HZ = 100_000_000;
    localparam int SLOW_HALF_MS = 250;
    localparam int FAST_HALF_MS = 50;
    localparam int SLOW_HALF_CYCLES = SLOW_HALF_MS * (CLK_HZ / 1000);
    localparam int FAST_HALF_CYCLES = FAST_HALF_MS * (CLK_HZ / 1000);

    localparam logic [7:0] CTRL_OFFS = 8'h00;
    localparam logic [7:0] REF_A_OFFS = 8'h04;
    localparam logic [7:0] REF_B_OFFS = 8'h08;
    localparam logic [7:0] REF_C_OFFS = 8'h0C;
    localparam logic [7:0] REF_D_OFFS = 8'h10;
    localparam logic [7:0] LIMIT_OFFS = 8'h14;
    localparam logic [7:0] STATUS_OFFS = 8'h18;

    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_EN_LSB = 2;
    localparam int REF_LEVEL_LSB = 0;
    localparam int REF_RAMP_LSB = 16;
    localparam int ST_DEMAND_LSB = 16;

    localparam logic [11:0] REF_LEVEL_RST = 12'h000;
    localparam logic [15:0] REF_RAMP_RST = 16'h0000;
    localparam logic [23:0] LIMIT_RST = 24'hFF_FFFF;
    localparam logic POWER_OPTION = 1'b1;

    typedef enum logic [1:0] {
        VDL_MODE_DEFAULT,
        VDL_MODE_INTERNAL,
        VDL_MODE_POWER
    } vdl_mode_t;

    typedef enum logic [1:0] {
        VDL_EN_DEFAULT,
        VDL_EN_REVERSE,
        VDL_EN_OFF
    } vdl_en_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } vdl_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } vdl_wb_rsp_t;

    // Pin bits: 5 alarm, 4 malfunction, 3 short, 2 open, 1 second input, 0 first input.
    typedef struct packed {
        logic alarm;
        logic malfunction;
        logic coil_short;
        logic coil_open;
        logic command_input_second;
        logic command_input_first;
    } vdl_pins_t;

    typedef struct packed {
        logic [11:0] current_demand;
        logic [15:0] ramp_time;
        logic pwm_on;
        logic coil_led;
        logic status_led;
    } vdl_drive_t;

    typedef struct packed {
        logic [31:0] count;
        logic level;
    } vdl_blink_state_t;

endpackage

// File: logic/vdl_blinker.sv
`timescale 1ns/1ps
module vdl_blinker import vdl_pkg::*; #(
    parameter int HALF_CYCLES = 1000
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Square wave out.
    output logic blink_o
);

    vdl_blink_state_t state_reg;
    vdl_blink_state_t state_next;

    always_comb begin
        state_next = state_reg;
        if (state_reg.count >= 32'(HALF_CYCLES - 1)) begin
            state_next.count = 32'h0000_0000;
            state_next.level = ~state_reg.level;
        end else begin
            state_next.count = state_reg.count + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign blink_o = state_reg.level;

endmodule

// File: logic/vdl_valve_driver.sv
`timescale 1ns/1ps
module vdl_valve_driver import vdl_pkg::*; #(
    parameter int SLOW_CYCLES = SLOW_HALF_CYCLES,
    parameter int FAST_CYCLES = FAST_HALF_CYCLES
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave.
    input wire vdl_wb_req_t wb_i,
    output vdl_wb_rsp_t wb_o,
    // Converted analog values of both command inputs.
    input wire logic [11:0] command_input_first_value_i,
    input wire logic [11:0] command_input_second_value_i,
    // Asynchronous pin levels and power stage status.
    input wire vdl_pins_t pins_i,
    // Drive and indication.
    output vdl_drive_t drive_o
);

    typedef struct packed {
        vdl_mode_t mode;
        vdl_en_t en_sel;
        logic [3:0][11:0] ref_level;
        logic [3:0][15:0] ref_ramp;
        logic [23:0] limit;
        logic ack;
        logic [31:0] rdat;
        vdl_pins_t sync1;
        vdl_pins_t sync2;
        vdl_pins_t sync3;
        vdl_pins_t pins;
        logic [1:0] ref_idx;
        logic enabled;
        vdl_drive_t drive;
    } vdl_main_state_t;

    vdl_main_state_t state_reg;
    vdl_main_state_t state_next;
    logic slow_blink;
    logic fast_blink;

    vdl_blinker #(
        .HALF_CYCLES(SLOW_CYCLES)
    ) u_slow (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .blink_o(slow_blink)
    );

    vdl_blinker #(
        .HALF_CYCLES(FAST_CYCLES)
    ) u_fast (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .blink_o(fast_blink)
    );

    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

    always_comb begin
        logic access;
        logic [31:0] word;
        logic [11:0] target;
        logic [23:0] power;
        logic en_level;
        logic [1:0] wr_mode;
        logic [1:0] wr_en;
        access = 1'b0;
        word = 32'h0000_0000;
        target = 12'h000;
        power = 24'h00_0000;
        en_level = 1'b0;
        wr_mode = 2'b00;
        wr_en = 2'b00;
        state_next = state_reg;

        // A level change counts once the second and third stages agree.
        state_next.sync1 = pins_i;
        state_next.sync2 = state_reg.sync1;
        state_next.sync3 = state_reg.sync2;
        for (int i = 0; i < 6; i++) begin
            if (state_reg.sync2[i] == state_reg.sync3[i]) begin
                state_next.pins[i] = state_reg.sync3[i];
            end
        end

        // Bus: one registered ack per request, dropped the cycle after.
        access = wb_i.cyc && wb_i.stb && !state_reg.ack;
        state_next.ack = access;
        state_next.rdat = 32'h0000_0000;
        if (access && wb_i.we) begin
            if (wb_i.adr == CTRL_OFFS) begin
                word = merge({28'h000_0000, state_reg.en_sel, state_reg.mode}, wb_i.dat, wb_i.sel);
                wr_mode = word[CTRL_MODE_LSB +: 2];
                wr_en = word[CTRL_EN_LSB +: 2];
                // Power limitation without the option falls back to default mode.
                if (wr_mode == 2'(VDL_MODE_INTERNAL)) begin
                    state_next.mode = VDL_MODE_INTERNAL;
                end else if (wr_mode == 2'(VDL_MODE_POWER) && POWER_OPTION) begin
                    state_next.mode = VDL_MODE_POWER;
                end else begin
                    state_next.mode = VDL_MODE_DEFAULT;
                end
                if (wr_en == 2'(VDL_EN_REVERSE)) begin
                    state_next.en_sel = VDL_EN_REVERSE;
                end else if (wr_en == 2'(VDL_EN_OFF)) begin
                    state_next.en_sel = VDL_EN_OFF;
                end else begin
                    state_next.en_sel = VDL_EN_DEFAULT;
                end
            end else if (wb_i.adr >= REF_A_OFFS && wb_i.adr <= REF_D_OFFS
                         && wb_i.adr[1:0] == 2'b00) begin
                word = merge({state_reg.ref_ramp[wb_i.adr[3:2] - 2'd1], 4'h0,
                              state_reg.ref_level[wb_i.adr[3:2] - 2'd1]}, wb_i.dat, wb_i.sel);
                state_next.ref_level[wb_i.adr[3:2] - 2'd1] = word[REF_LEVEL_LSB +: 12];
                state_next.ref_ramp[wb_i.adr[3:2] - 2'd1] = word[REF_RAMP_LSB +: 16];
            end else if (wb_i.adr == LIMIT_OFFS) begin
                word = merge({8'h00, state_reg.limit}, wb_i.dat, wb_i.sel);
                state_next.limit = word[23:0];
            end
        end else if (access) begin
            if (wb_i.adr == CTRL_OFFS) begin
                state_next.rdat = {28'h000_0000, state_reg.en_sel, state_reg.mode};
            end else if (wb_i.adr >= REF_A_OFFS && wb_i.adr <= REF_D_OFFS
                         && wb_i.adr[1:0] == 2'b00) begin
                state_next.rdat = {state_reg.ref_ramp[wb_i.adr[3:2] - 2'd1], 4'h0,
                                   state_reg.ref_level[wb_i.adr[3:2] - 2'd1]};
            end else if (wb_i.adr == LIMIT_OFFS) begin
                state_next.rdat = {8'h00, state_reg.limit};
            end else if (wb_i.adr == STATUS_OFFS) begin
                state_next.rdat = {4'h0, state_reg.drive.current_demand, 6'h00,
                                   state_reg.pins.alarm, state_reg.pins.malfunction,
                                   state_reg.pins.coil_short, state_reg.pins.coil_open,
                                   state_reg.drive.status_led, state_reg.drive.coil_led,
                                   state_reg.drive.pwm_on, state_reg.enabled,
                                   state_reg.ref_idx};
            end
        end

        // Input combination order: both low, first only, both high, second only.
        state_next.ref_idx = {state_reg.pins.command_input_second,
                              state_reg.pins.command_input_second
                              ^ state_reg.pins.command_input_first};

        // Enable polarity lets two drivers share one reference and one select line.
        en_level = state_reg.pins.command_input_second;
        case (state_reg.mode)
            VDL_MODE_DEFAULT: begin
                target = command_input_first_value_i;
                case (state_reg.en_sel)
                    VDL_EN_DEFAULT: state_next.enabled = en_level;
                    VDL_EN_REVERSE: state_next.enabled = ~en_level;
                    default: state_next.enabled = 1'b1;
                endcase
            end
            VDL_MODE_INTERNAL: begin
                target = state_reg.ref_level[state_reg.ref_idx];
                state_next.enabled = 1'b1;
            end
            default: begin
                target = command_input_first_value_i;
                state_next.enabled = 1'b1;
            end
        endcase
        state_next.drive.ramp_time = state_reg.mode == VDL_MODE_INTERNAL ?
                                     state_reg.ref_ramp[state_reg.ref_idx] : REF_RAMP_RST;

        // In power mode the demand walks one step a cycle so the product needs no divider.
        if (!state_reg.enabled) begin
            state_next.drive.current_demand = 12'h000;
        end else if (state_reg.mode == VDL_MODE_POWER) begin
            power = 24'(state_reg.drive.current_demand) * 24'(command_input_second_value_i);
            if (power > state_reg.limit || state_reg.drive.current_demand > target) begin
                if (state_reg.drive.current_demand != 12'h000) begin
                    state_next.drive.current_demand = state_reg.drive.current_demand - 12'h001;
                end
            end else if (state_reg.drive.current_demand < target) begin
                state_next.drive.current_demand = state_reg.drive.current_demand + 12'h001;
            end
        end else begin
            state_next.drive.current_demand = target;
        end
        state_next.drive.pwm_on = state_reg.enabled && state_reg.drive.current_demand != 12'h000;

        if (state_reg.pins.coil_short) begin
            state_next.drive.coil_led = fast_blink;
        end else if (state_reg.pins.coil_open) begin
            state_next.drive.coil_led = slow_blink;
        end else begin
            state_next.drive.coil_led = state_reg.drive.pwm_on;
        end

        if (state_reg.pins.malfunction) begin
            state_next.drive.status_led = 1'b1;
        end else if (!state_reg.enabled || state_reg.pins.alarm || state_reg.pins.coil_open
                     || state_reg.pins.coil_short) begin
            state_next.drive.status_led = slow_blink;
        end else begin
            state_next.drive.status_led = fast_blink;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= '0;
            state_reg.limit <= LIMIT_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign wb_o.ack = state_reg.ack;
    assign wb_o.dat = state_reg.rdat;
    assign drive_o = state_reg.drive;

endmodule

// File: verification/vdl_valve_driver_props.sv
`timescale 1ns/1ps
module vdl_valve_driver_chk import vdl_pkg::*; #(
    parameter int SLOW_CYCLES = 8,
    parameter int FAST_CYCLES = 2
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus.
    input wire vdl_wb_req_t wb_i,
    input wire vdl_wb_rsp_t wb_o,
    // Command inputs and pins.
    input wire logic [11:0] command_input_first_value_i,
    input wire logic [11:0] command_input_second_value_i,
    input wire vdl_pins_t pins_i,
    // Drive.
    input wire vdl_drive_t drive_o
);
    // Windows hold one full blink period plus pipeline slack.
    localparam int SWIN = 2 * SLOW_CYCLES + 4;
    localparam int FWIN = 2 * FAST_CYCLES + 4;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_next: assert property (wb_i.cyc && wb_i.stb && !wb_o.ack |=> wb_o.ack)
        else $error("bus request not acknowledged");
    a_ack_pulse: assert property (wb_o.ack |=> !wb_o.ack)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (wb_o.ack |-> $past(wb_i.cyc && wb_i.stb))
        else $error("ack without request");
    a_dat_idle: assert property (!wb_o.ack |-> wb_o.dat == 32'h0000_0000)
        else $error("read data outside ack");
    a_pwm_demand: assert property (
        drive_o.pwm_on |-> $past(drive_o.current_demand) != 12'h000)
        else $error("pwm on with zero demand");
    a_coil_pwm: assert property (
        (!pins_i.coil_open && !pins_i.coil_short)[*8] ##1
        (!pins_i.coil_open && !pins_i.coil_short)[*4]
        |-> drive_o.coil_led == $past(drive_o.pwm_on))
        else $error("coil led not following pwm");
    a_open_blink: assert property (
        (pins_i.coil_open && !pins_i.coil_short)[*8] ##1
        (pins_i.coil_open && !pins_i.coil_short)[*4]
        |-> ##[0:SWIN] $changed(drive_o.coil_led))
        else $error("coil led not blinking on open coil");
    a_short_blink: assert property (
        pins_i.coil_short[*8] ##1 pins_i.coil_short[*4]
        |-> ##[0:FWIN] $changed(drive_o.coil_led))
        else $error("coil led not blinking on short");
    a_malf_on: assert property (
        pins_i.malfunction[*8] ##1 pins_i.malfunction[*4] |-> drive_o.status_led)
        else $error("status led not on for malfunction");
endmodule
bind vdl_valve_driver vdl_valve_driver_chk #(.SLOW_CYCLES(SLOW_CYCLES),
    .FAST_CYCLES(FAST_CYCLES)) chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o),
    .command_input_first_value_i(command_input_first_value_i), .command_input_second_value_i(command_input_second_value_i), .pins_i(pins_i), .drive_o(drive_o));

// File: verification/vdl_plc_model.sv
`timescale 1ns/1ps
module vdl_plc_model (
    // Clock.
    input wire logic clk_i,
    // Wanted regulation, pressure and on/off levels.
    input wire logic [11:0] ref_i,
    input wire logic [11:0] press_i,
    input wire logic [1:0] lvl_i,
    // Command lines.
    output logic [11:0] command_input_first_value_o,
    output logic [11:0] command_input_second_value_o,
    output logic [1:0] lvl_o
);
    // Reference, pressure and both levels, updated together so no mixed state shows.
    always_ff @(posedge clk_i) begin
        command_input_first_value_o <= ref_i;
        command_input_second_value_o <= press_i;
        lvl_o <= lvl_i;
    end
endmodule

// File: verification/vdl_valve_driver_tb.sv
`timescale 1ns/1ps
module vdl_valve_driver_tb import vdl_pkg::*;;
    localparam int SLOW = 8;
    localparam int FAST = 2;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    vdl_wb_req_t req = '0;
    vdl_wb_rsp_t rsp;
    vdl_drive_t drv;
    vdl_pins_t pins_w;
    logic [11:0] ref_v = 12'h000;
    logic [11:0] press_v = 12'h000;
    logic [1:0] lvl = 2'b00;
    logic [3:0] flt = 4'h0;
    logic [11:0] command_input_first_w;
    logic [11:0] command_input_second_w;
    logic [1:0] lvl_w;
    logic [31:0] rd;
    logic [31:0] n;
    logic [31:0] want;
    logic [1:0] combo [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;
    assign pins_w = {flt, lvl_w};
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    vdl_plc_model plc_u (.clk_i(clk_i), .ref_i(ref_v), .press_i(press_v), .lvl_i(lvl),
        .command_input_first_value_o(command_input_first_w), .command_input_second_value_o(command_input_second_w), .lvl_o(lvl_w));
    vdl_valve_driver #(.SLOW_CYCLES(SLOW), .FAST_CYCLES(FAST)) dut_u (.clk_i(clk_i),
        .rst_i(rst_i), .wb_i(req), .wb_o(rsp), .command_input_first_value_i(command_input_first_w), .command_input_second_value_i(command_input_second_w),
        .pins_i(pins_w), .drive_o(drv));
    task give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task chk_drv(input logic [11:0] d, input logic [15:0] r, input logic p, input logic c);
        chk(32'({drv.current_demand, drv.ramp_time, drv.pwm_on, drv.coil_led}), 32'({d, r, p, c}));
    endtask
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
        do @(posedge clk_i); while (rsp.ack !== 1'b1);
        rd = rsp.dat;
        req <= '0;
    endtask
    // Pin changes pass a three-stage synchroniser, so allow the full pipeline.
    task settle();
        repeat (12) @(posedge clk_i);
    endtask
    task half(input bit st);
        logic p;
        for (int k = 0; k < 2; k++) begin
            p = st ? drv.status_led : drv.coil_led;
            n = 0;
            while ((st ? drv.status_led : drv.coil_led) === p && n < 100) begin
                @(posedge clk_i);
                n++;
            end
        end
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            give_verdict();
        end
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, CTRL_OFFS, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        wb(1'b0, 8'h40, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        wb(1'b1, CTRL_OFFS, 32'h0000_000F);
        wb(1'b0, CTRL_OFFS, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        $display("test reset done");
        ref_v <= 12'h123;
        lvl <= 2'b10;
        settle();
        chk_drv(12'h123, 16'h0000, 1'b1, 1'b1);
        half(1'b1);
        chk(n, FAST);
        lvl <= 2'b00;
        settle();
        chk(32'({drv.pwm_on, drv.coil_led}), 32'h0000_0000);
        half(1'b1);
        chk(n, SLOW);
        for (int e = 0; e < 3; e++) begin
            for (int l = 0; l < 2; l++) begin
                wb(1'b1, CTRL_OFFS, 32'(e << CTRL_EN_LSB));
                lvl <= {l[0], 1'b0};
                settle();
                want = 32'(e == 2 || (e == 0 && l == 1) || (e == 1 && l == 0));
                chk(32'(drv.pwm_on), want);
            end
        end
        $display("test polarity done");
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, REF_A_OFFS + 8'(4 * i),
               {16'(16'h1000 * (i + 1)), 4'h0, 12'(12'h111 * (i + 1))});
        end
        wb(1'b1, CTRL_OFFS, 32'h0000_0001);
        for (int i = 0; i < 4; i++) begin
            lvl <= combo[i];
            settle();
            chk_drv(12'(12'h111 * (i + 1)), 16'(16'h1000 * (i + 1)), 1'b1, 1'b1);
        end
        wb(1'b0, STATUS_OFFS, 32'h0000_0000);
        chk(rd & 32'hFFFF_FFDF, 32'h0444_001F);
        wb(1'b0, REF_D_OFFS, 32'h0000_0000);
        chk(rd, 32'h4000_0444);
        $display("test internal done");
        wb(1'b1, CTRL_OFFS, 32'h0000_0002);
        ref_v <= 12'h100;
        lvl <= 2'b00;
        // The demand walks down one step a cycle from the last stored level.
        repeat (900) @(posedge clk_i);
        chk_drv(12'h100, 16'h0000, 1'b1, 1'b1);
        wb(1'b1, LIMIT_OFFS, 32'h0000_1000);
        press_v <= 12'h100;
        repeat (300) @(posedge clk_i);
        chk(32'(drv.current_demand[11:1]), 32'h0000_0008);
        $display("test power done");
        wb(1'b1, CTRL_OFFS, 32'h0000_0000);
        lvl <= 2'b10;
        flt <= 4'b0001;
        settle();
        half(1'b0);
        chk(n, SLOW);
        half(1'b1);
        chk(n, SLOW);
        flt <= 4'b0011;
        settle();
        half(1'b0);
        chk(n, FAST);
        flt <= 4'b1000;
        settle();
        half(1'b1);
        chk(n, SLOW);
        flt <= 4'b0100;
        settle();
        chk(32'(drv.status_led), 32'h0000_0001);
        $display("test leds done");
        give_verdict();
    end
endmodule
